// file: include/flash_map.svh
// constants and field layout of the serial flash status, protect and id block
//
// Contract
// - power-up, disable, status write, program and erase completion clear latch
// - id read returns maker, type, capacity, length 10h, sixteen data bytes
// - customer data bytes are read-only and default to 00h
// - id read during program or erase is ignored, cycle unaffected
// - id output bits change on the falling serial clock edge
// - raising select ends id output; device returns to standby
// - status read allowed anytime, repeats current status while clocked
// - busy flag is one during status write, program or erase
// - latch flag mirrors latch; when zero, writes are rejected
// - protect bits written only by status write; nonzero guards area
// - bulk erase runs only when all protect bits are zero
// - disable bit set with protect pin low makes status read-only
// - status write accepted only with the latch already set
// - status write is opcode plus one byte, select rises after it
// - status write keeps b7 b4 b3 b2; b6 b5 read zero
// - valid status write starts timed cycle, busy, latch clears after
// - disable bit zero: status write allowed with latch, any pin level
// - disable bit one, pin high: status write allowed with latch
// - hardware protection holds whichever condition came first
// - only raising the protect pin leaves hardware protection; here reset also clears the disable bit and leaves it
// - write-class instructions must end on a whole byte boundary
// - enable opcode 06h sets the latch
// - opcodes sent msb first: 04h 05h 01h 9Fh
`ifndef FLASH_MAP_SVH
`define FLASH_MAP_SVH

`define CLK_PERIOD_NS 10
`define WRITE_CYCLE_NS 10000
`define WRITE_CYCLE_CYCLES \
  ((`WRITE_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WR_CNT_W 10

`define SR_BUSY 0
`define SR_WEL 1
`define SR_BP_LO 2
`define SR_BP_HI 4
`define SR_SWD 7
`define SR_BP_RESET 3'h0
`define SR_SWD_RESET 1'h0

`define ID_LEN_BYTE 8'h10
`define ID_LEN_POS 5'h04
`define ID_CFD_COUNT 16

`define BYTES_ONE 5'h01
`define BYTES_STATUS_WRITE_CMD 5'h02
`define BYTES_SE 5'h04
`define BYTES_PP_MIN 5'h05
`define BYTES_MAX 5'h1F

`endif

// file: include/flash_pkg.sv
// types of the serial flash status, protect and id block
package flash_pkg;

  typedef enum logic [7:0] {
    OP_WRITE_ENABLE = 8'h06,
    OP_WRITE_DISABLE = 8'h04,
    OP_STATUS_READ = 8'h05,
    OP_STATUS_WRITE = 8'h01,
    OP_IDENT_READ = 8'h9F,
    OP_PAGE_PROGRAM = 8'h02,
    OP_SECTOR_ERASE = 8'hD8,
    OP_BULK_ERASE = 8'hC7
  } opcode_t;

  typedef enum logic [1:0] {
    RD_NONE = 2'b00,
    RD_STATUS = 2'b01,
    RD_IDENT = 2'b10
  } read_mode_t;

  typedef enum logic {
    WR_IDLE = 1'b0,
    WR_BUSY = 1'b1
  } write_state_t;

  typedef enum logic [1:0] {
    ARR_NONE = 2'b00,
    ARR_PAGE = 2'b01,
    ARR_SECTOR = 2'b10,
    ARR_BULK = 2'b11
  } array_op_t;

  typedef struct packed {
    logic start;
    array_op_t op;
    logic [2:0] block_protect;
  } array_req_t;

endpackage

// file: logic/serial_flash_status_protect_id.sv
// command front end of a serial flash: latch, status, protection and id read
`timescale 1ns/1ps
`include "flash_map.svh"

module serial_flash_status_protect_id #(
  // identity bytes: arbitrary values
  parameter logic [7:0] MAKER_CODE = 8'hA5,
  parameter logic [7:0] TYPE_CODE = 8'h5A,
  parameter logic [7:0] CAPACITY_CODE = 8'h3C,
  // customer data, first byte in the top bits
  parameter logic [127:0] CUSTOMER_FACTORY_DATA = 128'h0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic wp_n,
  output logic miso_out,
  output logic miso_oe,
  input wire logic array_busy,
  input wire logic array_done,
  output flash_pkg::array_req_t array_req
);

  // serial clock domain
  logic frame_start;
  logic [2:0] bit_cnt;
  logic [4:0] byte_cnt;
  logic [7:0] shift;
  logic [7:0] opcode_l;
  logic [7:0] data_l;
  logic frame_tgl;
  logic [7:0] rx_byte;
  flash_pkg::read_mode_t rd_mode;
  logic [7:0] st_meta;
  logic [7:0] st_sync;
  logic [7:0] tx;
  logic [7:0] next_tx;
  logic tx_load;
  logic [4:0] id_idx;
  logic [3:0] cfd_idx;
  logic [7:0] cfd_byte [`ID_CFD_COUNT];

  // system clock domain
  logic cs_meta;
  logic cs_s;
  logic cs_prev;
  logic tgl_meta;
  logic tgl_s;
  logic tgl_seen;
  logic wp_meta;
  logic wp_s;
  logic frame_end;
  logic whole_bytes;
  logic write_enable_latch;
  logic status_write_disable_bit;
  logic [2:0] bp;
  logic hw_protect;
  logic busy;
  logic do_write_enable_cmd;
  logic do_write_disable_cmd;
  logic do_status_write_cmd;
  logic [7:0] pend;
  flash_pkg::write_state_t wr_state;
  logic [`WR_CNT_W-1:0] wr_cnt;
  logic wr_finish;
  logic [7:0] status_reg;
  flash_pkg::array_req_t next_array_req;

  localparam logic [`WR_CNT_W-1:0] WR_LAST =
    `WR_CNT_W'(`WRITE_CYCLE_CYCLES - 1);

  assign rx_byte = {shift[6:0], mosi};

  // set while deselected, so the first rising edge knows a frame began
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      frame_start <= 1'b1;
    end
    else
    begin
      frame_start <= 1'b0;
    end
  end

  // bit and byte counting; values hold after the frame for the clk side
  always_ff @(posedge sclk)
  begin
    shift <= rx_byte;
    if (frame_start)
    begin
      bit_cnt <= 3'h1;
      byte_cnt <= 5'h00;
    end
    else
    begin
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7 && byte_cnt != `BYTES_MAX)
      begin
        byte_cnt <= byte_cnt + 5'h01;
      end
    end
  end

  // opcode and first data byte, msb first
  always_ff @(posedge sclk)
  begin
    if (!frame_start && bit_cnt == 3'h7)
    begin
      if (byte_cnt == 5'h00)
      begin
        opcode_l <= rx_byte;
      end
      if (byte_cnt == 5'h01)
      begin
        data_l <= rx_byte;
      end
    end
  end

  // one toggle per clocked frame; an empty select pulse never toggles
  always_ff @(posedge sclk or posedge rst)
  begin
    if (rst)
    begin
      frame_tgl <= 1'b0;
    end
    else if (frame_start)
    begin
      frame_tgl <= ~frame_tgl;
    end
  end

  // status crosses bitwise; eight opcode edges refresh it before output
  always_ff @(posedge sclk)
  begin
    st_meta <= status_reg;
    st_sync <= st_meta;
  end

  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      rd_mode <= flash_pkg::RD_NONE;
    end
    else if (!frame_start && bit_cnt == 3'h7 && byte_cnt == 5'h00)
    begin
      case (rx_byte)
        flash_pkg::OP_STATUS_READ:
          rd_mode <= flash_pkg::RD_STATUS;
        flash_pkg::OP_IDENT_READ:
          rd_mode <= st_sync[`SR_BUSY] ? flash_pkg::RD_NONE
                                       : flash_pkg::RD_IDENT;
        default:
          rd_mode <= flash_pkg::RD_NONE;
      endcase
    end
  end

  generate
    for (genvar g = 0; g < `ID_CFD_COUNT; g++)
    begin : g_cfd
      // fixed at build time, nothing can write it
      assign cfd_byte[g] = CUSTOMER_FACTORY_DATA[127 - 8 * g -: 8];
    end
  endgenerate

  assign id_idx = byte_cnt - 5'h01;
  // first customer byte follows the length byte, at index 4 of the reply
  assign cfd_idx = 4'(id_idx - `ID_LEN_POS);

  always_comb
  begin
    next_tx = 8'h00;
    case (rd_mode)
      flash_pkg::RD_STATUS:
        next_tx = st_sync;
      flash_pkg::RD_IDENT:
      begin
        if (id_idx == 5'h00)
        begin
          next_tx = MAKER_CODE;
        end
        else if (id_idx == 5'h01)
        begin
          next_tx = TYPE_CODE;
        end
        else if (id_idx == 5'h02)
        begin
          next_tx = CAPACITY_CODE;
        end
        else if (id_idx == 5'h03)
        begin
          next_tx = `ID_LEN_BYTE;
        end
        else if (id_idx <= 5'h13)
        begin
          next_tx = cfd_byte[cfd_idx];
        end
      end
      default:
        next_tx = 8'h00;
    endcase
  end

  assign tx_load = !frame_start && bit_cnt == 3'h0 && byte_cnt != 5'h00
                   && rd_mode != flash_pkg::RD_NONE;

  // output shifts on the falling edge; select high drops it at once
  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      tx <= 8'h00;
      miso_oe <= 1'b0;
    end
    else if (tx_load)
    begin
      tx <= next_tx;
      miso_oe <= 1'b1;
    end
    else
    begin
      tx <= {tx[6:0], 1'b0};
    end
  end

  assign miso_out = tx[7];

  // pins and frame toggle into the clk domain
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cs_meta <= 1'b1;
      cs_s <= 1'b1;
      cs_prev <= 1'b1;
      tgl_meta <= 1'b0;
      tgl_s <= 1'b0;
      tgl_seen <= 1'b0;
      wp_meta <= 1'b1;
      wp_s <= 1'b1;
    end
    else
    begin
      cs_meta <= cs_n;
      cs_s <= cs_meta;
      cs_prev <= cs_s;
      tgl_meta <= frame_tgl;
      tgl_s <= tgl_meta;
      wp_meta <= wp_n;
      wp_s <= wp_meta;
      if (cs_s && !cs_prev)
      begin
        tgl_seen <= tgl_s;
      end
    end
  end

  // frame counters are still while deselected, so reading them here is safe
  assign frame_end = cs_s && !cs_prev && (tgl_s != tgl_seen);
  assign whole_bytes = bit_cnt == 3'h0;
  assign busy = (wr_state == flash_pkg::WR_BUSY) || array_busy;
  // level based, so entry order does not matter and pin high leaves it
  assign hw_protect = status_write_disable_bit && !wp_s;

  // write-class commands are ignored while any cycle runs
  assign do_write_enable_cmd = frame_end && whole_bytes && byte_cnt == `BYTES_ONE
                   && opcode_l == flash_pkg::OP_WRITE_ENABLE && !busy;
  assign do_write_disable_cmd = frame_end && whole_bytes && byte_cnt == `BYTES_ONE
                   && opcode_l == flash_pkg::OP_WRITE_DISABLE && !busy;
  assign do_status_write_cmd = frame_end && whole_bytes && byte_cnt == `BYTES_STATUS_WRITE_CMD
                   && opcode_l == flash_pkg::OP_STATUS_WRITE
                   && write_enable_latch && !busy && !hw_protect;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_state <= flash_pkg::WR_IDLE;
      wr_cnt <= '0;
      pend <= 8'h00;
    end
    else
    begin
      case (wr_state)
        flash_pkg::WR_IDLE:
        begin
          if (do_status_write_cmd)
          begin
            wr_state <= flash_pkg::WR_BUSY;
            wr_cnt <= WR_LAST;
            pend <= data_l;
          end
        end
        flash_pkg::WR_BUSY:
        begin
          if (wr_cnt == '0)
          begin
            wr_state <= flash_pkg::WR_IDLE;
          end
          else
          begin
            wr_cnt <= wr_cnt - `WR_CNT_W'(1);
          end
        end
        default:
          wr_state <= flash_pkg::WR_IDLE;
      endcase
    end
  end

  assign wr_finish = wr_state == flash_pkg::WR_BUSY && wr_cnt == '0;

  // only b7 and b4..b2 take the written byte
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      status_write_disable_bit <= `SR_SWD_RESET;
      bp <= `SR_BP_RESET;
    end
    else if (wr_finish)
    begin
      status_write_disable_bit <= pend[`SR_SWD];
      bp <= pend[`SR_BP_HI:`SR_BP_LO];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      write_enable_latch <= 1'b0;
    end
    else if (do_write_enable_cmd)
    begin
      write_enable_latch <= 1'b1;
    end
    else if (do_write_disable_cmd || wr_finish || array_done)
    begin
      write_enable_latch <= 1'b0;
    end
  end

  // registered so the serial side samples a clean byte
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      status_reg <= 8'h00;
    end
    else
    begin
      status_reg <= {status_write_disable_bit, 2'b00, bp, write_enable_latch, busy};
    end
  end

  // program and erase only start here; the area check uses block_protect
  always_comb
  begin
    next_array_req = '0;
    next_array_req.block_protect = bp;
    if (frame_end && whole_bytes && write_enable_latch && !busy)
    begin
      if (opcode_l == flash_pkg::OP_PAGE_PROGRAM
          && byte_cnt >= `BYTES_PP_MIN)
      begin
        next_array_req.start = 1'b1;
        next_array_req.op = flash_pkg::ARR_PAGE;
      end
      else if (opcode_l == flash_pkg::OP_SECTOR_ERASE
               && byte_cnt == `BYTES_SE)
      begin
        next_array_req.start = 1'b1;
        next_array_req.op = flash_pkg::ARR_SECTOR;
      end
      else if (opcode_l == flash_pkg::OP_BULK_ERASE
               && byte_cnt == `BYTES_ONE && bp == 3'h0)
      begin
        next_array_req.start = 1'b1;
        next_array_req.op = flash_pkg::ARR_BULK;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      array_req <= '0;
    end
    else
    begin
      array_req <= next_array_req;
    end
  end

  property p_write_disable_cmd_clears;
    @(posedge clk) disable iff (rst)
    do_write_disable_cmd |=> !write_enable_latch ##1 !status_reg[`SR_WEL];
  endproperty
  a_write_disable_cmd_clears: assert property (p_write_disable_cmd_clears)
    else $error("latch still set after write disable");

  property p_busy_reads_one;
    @(posedge clk) disable iff (rst)
    do_status_write_cmd |-> ##2 status_reg[`SR_BUSY] [*8];
  endproperty
  a_busy_reads_one: assert property (p_busy_reads_one)
    else $error("busy flag low during status write cycle");

  property p_status_write_cmd_needs_latch;
    @(posedge clk) disable iff (rst)
    do_status_write_cmd |-> write_enable_latch && status_reg[`SR_WEL];
  endproperty
  a_status_write_cmd_needs_latch: assert property (p_status_write_cmd_needs_latch)
    else $error("status write accepted without latch");

  property p_hw_protect_blocks;
    @(posedge clk) disable iff (rst)
    (status_write_disable_bit && !wp_s) |-> !do_status_write_cmd ##1 wr_state != flash_pkg::WR_BUSY
      || $past(wr_state) == flash_pkg::WR_BUSY;
  endproperty
  a_hw_protect_blocks: assert property (p_hw_protect_blocks)
    else $error("status write started under hardware protection");

  property p_finish_updates;
    @(posedge clk) disable iff (rst)
    wr_finish |=> !write_enable_latch && status_write_disable_bit == $past(pend[`SR_SWD])
      && bp == $past(pend[`SR_BP_HI:`SR_BP_LO]);
  endproperty
  a_finish_updates: assert property (p_finish_updates)
    else $error("status write completion wrong");

  property p_bp_only_by_write;
    @(posedge clk) disable iff (rst)
    !wr_finish |=> $stable(bp) && $stable(status_write_disable_bit);
  endproperty
  a_bp_only_by_write: assert property (p_bp_only_by_write)
    else $error("protect bits changed outside status write");

  property p_bulk_guard;
    @(posedge clk) disable iff (rst)
    array_req.start && array_req.op == flash_pkg::ARR_BULK
      |-> $past(bp) == 3'h0 && $past(write_enable_latch);
  endproperty
  a_bulk_guard: assert property (p_bulk_guard)
    else $error("bulk erase with protect bits set");

  property p_write_enable_cmd_sets;
    @(posedge clk) disable iff (rst)
    do_write_enable_cmd |=> write_enable_latch ##1 status_reg[`SR_WEL];
  endproperty
  a_write_enable_cmd_sets: assert property (p_write_enable_cmd_sets)
    else $error("write enable did not set latch");

  property p_reserved_zero;
    @(posedge clk) disable iff (rst)
    wr_finish |-> ##2 status_reg[6:5] == 2'b00
      && status_reg[`SR_SWD] == $past(pend[`SR_SWD], 2);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("status byte layout wrong after write");

  property p_id_length;
    @(negedge sclk) disable iff (cs_n)
    tx_load && rd_mode == flash_pkg::RD_IDENT && id_idx == 5'h03
      |=> tx == `ID_LEN_BYTE;
  endproperty
  a_id_length: assert property (p_id_length)
    else $error("length byte wrong in id output");

endmodule

// file: sim/spi_host_model.sv
// spi host model: drives select, serial clock and data in whole frames
`timescale 1ns/1ps

module spi_host_model (
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso_out,
  input wire logic miso_oe
);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // mode 0, 48 ns period; the clock stands low between frames
  task automatic xfer(input logic [31:0] tx, input int nb,
    output logic [167:0] rx, output logic oe_any);
    rx = '0;
    oe_any = 1'b0;
    cs_n = 1'b0;
    for (int i = 0; i < nb; i++)
    begin
      mosi = (i < 32) ? tx[31 - i] : 1'b0;
      #24;
      sclk = 1'b1;
      rx = {rx[166:0], miso_out};
      oe_any = oe_any | miso_oe;
      #24;
      sclk = 1'b0;
    end
    #24;
    // select may rise after any bit, also mid-byte
    cs_n = 1'b1;
    // a released line must not keep showing the last bit
    mosi = ~mosi;
    #200;
  endtask
endmodule

// file: sim/serial_flash_status_protect_id_tb.sv
// self-checking bench of the serial flash status, protect and id block
`timescale 1ns/1ps

module serial_flash_status_protect_id_tb;
  localparam logic [31:0] WE = {flash_pkg::OP_WRITE_ENABLE, 24'h000000};
  localparam logic [31:0] WD = {flash_pkg::OP_WRITE_DISABLE, 24'h000000};
  localparam logic [31:0] SR = {flash_pkg::OP_STATUS_READ, 24'h000000};
  localparam logic [31:0] ID = {flash_pkg::OP_IDENT_READ, 24'h000000};
  localparam logic [31:0] BE = {flash_pkg::OP_BULK_ERASE, 24'h000000};
  localparam logic [31:0] SE = {flash_pkg::OP_SECTOR_ERASE, 24'h012345};
  logic clk, rst, sclk, cs_n, mosi, wp_n, miso_out, miso_oe;
  logic array_busy, array_done, oe, ok;
  flash_pkg::array_req_t array_req, last_req;
  int miscompares = 0;
  int num_checks = 0;
  int starts = 0;
  int seed = 32'h97A9EBBD;
  int m_wel = 0;
  int m_swd = 0;
  int m_bp = 0;
  int n;
  logic [167:0] rx;
  logic [7:0] d, st;
  logic [4:0] wp_tab = 5'h14;

  // identity values here are arbitrary
  serial_flash_status_protect_id #(
    .MAKER_CODE(8'hA5),
    .TYPE_CODE(8'h5A),
    .CAPACITY_CODE(8'h3C)
  ) uut (
    .clk(clk),
    .rst(rst),
    .sclk(sclk),
    .cs_n(cs_n),
    .mosi(mosi),
    .wp_n(wp_n),
    .miso_out(miso_out),
    .miso_oe(miso_oe),
    .array_busy(array_busy),
    .array_done(array_done),
    .array_req(array_req)
  );

  spi_host_model host (
    .sclk(sclk),
    .cs_n(cs_n),
    .mosi(mosi),
    .miso_out(miso_out),
    .miso_oe(miso_oe)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
    if (array_req.start === 1'b1)
    begin
      starts++;
      last_req = array_req;
    end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // output may only move while the serial clock is low
  always @(miso_out)
    if (miso_oe === 1'b1 && sclk === 1'b1)
      check(32'h0, 32'h1);

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic logic [7:0] mstat();
    return {m_swd[0], 2'b00, m_bp[2:0], m_wel[0], 1'b0};
  endfunction

  task automatic cmd(input logic [31:0] tx, input int nb);
    host.xfer(tx, nb, rx, oe);
  endtask

  task automatic status_read_cmd();
    cmd(SR, 16);
    st = rx[7:0];
  endtask

  task automatic chk_st();
    status_read_cmd();
    check({24'h0, st}, {24'h0, mstat()});
  endtask

  task automatic pulse_done();
    @(negedge clk);
    array_done = 1'b1;
    array_busy = 1'b0;
    @(negedge clk);
    array_done = 1'b0;
    m_wel = 0;
  endtask

  initial
  begin
    #900000;
    miscompares++;
    stop_test();
  end

  initial
  begin
    rst = 1'b1;
    wp_n = 1'b1;
    array_busy = 1'b0;
    array_done = 1'b0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk_st();
    cmd(ID, 176);
    check({8'h0, rx[167:144]}, 32'h00A55A3C);
    check({24'h0, rx[143:136]}, 32'h10);
    for (int k = 4; k < 21; k++)
      check({24'h0, rx[167 - 8 * k -: 8]}, 32'h0);
    check({31'h0, oe}, 32'h1);
    $display("test id read done");
    cmd(WE, 8);
    m_wel = 1;
    chk_st();
    cmd(WD, 8);
    m_wel = 0;
    chk_st();
    cmd(WE, 9);
    chk_st();
    cmd({flash_pkg::OP_STATUS_WRITE, 8'h9C, 16'h0}, 16);
    chk_st();
    $display("test latch done");
    cmd(WE, 8);
    cmd(BE, 8);
    m_wel = 1;
    check(starts, 1);
    check({26'h0, last_req}, {26'h0, 1'b1, flash_pkg::ARR_BULK, 3'h0});
    @(negedge clk);
    array_busy = 1'b1;
    status_read_cmd();
    check({24'h0, st}, {24'h0, mstat() | 8'h01});
    cmd(ID, 176);
    check({31'h0, oe}, 32'h0);
    pulse_done();
    chk_st();
    $display("test array done");
    for (int i = 0; i < 5; i++)
    begin
      @(negedge clk);
      wp_n = wp_tab[i];
      cmd(WE, 8);
      m_wel = 1;
      d = 8'($random(seed));
      d[7] = (i < 4);
      d[2] = d[2] | (i == 4);
      ok = (m_swd == 0) || wp_n;
      cmd({flash_pkg::OP_STATUS_WRITE, d, 16'h0}, 16);
      if (ok)
      begin
        status_read_cmd();
        check({31'h0, st[0]}, 32'h1);
        n = 0;
        // host polls busy before going on
        while (st[0] !== 1'b0 && n < 40)
        begin
          status_read_cmd();
          n++;
        end
        if (n == 40)
        begin
          miscompares++;
          stop_test();
        end
        m_wel = 0;
        m_swd = d[7];
        m_bp = d[4:2];
      end
      chk_st();
    end
    $display("test protection done");
    cmd(WE, 8);
    cmd(BE, 8);
    m_wel = 1;
    check(starts, 1);
    cmd(SE, 32);
    check(starts, 2);
    check({26'h0, last_req},
      {26'h0, 1'b1, flash_pkg::ARR_SECTOR, 3'(m_bp)});
    pulse_done();
    chk_st();
    cmd(WE, 8);
    cmd({flash_pkg::OP_STATUS_WRITE, 8'h00, 16'h0}, 24);
    m_wel = 1;
    chk_st();
    cmd(ID, 20);
    check({31'h0, miso_oe}, 32'h0);
    cmd(SR, 32);
    check({8'h0, rx[23:0]}, {8'h0, {3{mstat()}}});
    $display("test framing done");
    stop_test();
  end
endmodule
